// file: hrs_halt_reaction_selector.sv
// Halt reaction selector: power state tracking and braking choice.
// Function
// - Entering quick-stop-active runs the action of the quick stop option.
// - Option zero disables the driver at once; the motor coasts.
// - Quick stop 1 slow ramp, 2 quick ramp, then switch-on-disabled.
// - Quick stop 5 or 6 brakes and stays energised in quick-stop-active.
// - An actuated limit switch also enters quick-stop-active.
// - Shutdown option: 0 coasts, 1 slow ramp then ready-to-switch-on.
// - Disable-operation option: 0 coasts, 1 slow ramp then switched-on.
// - Control word bit 8 runs the action of the halt option.
// - Halt is honoured only in PP, VL, PV, TQ and IP modes.
// - Halt option 1 slow ramp, 2 quick ramp; others reserved.
// - On a fault brake per fault option: 0 coast, 1 slow, 2 quick.
// - Every detected error stores an error code in the history; a fault and a following error in one cycle store only the fault code.
// - Following error option: -1 none, 0 coast, 1 slow, 2 quick.
// - Window -1 or slippage limit 7FFFFFFF disables following monitoring.
// - Slow ramp uses mode deceleration; quick ramp uses its own setting.
// - Quick stop return and fault reset need a rising bit edge.
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
module hrs_halt_reaction_selector (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic limitSwitch,
	input wire logic faultEvent,
	input wire logic followErr,
	input wire logic slipErr,
	input wire logic speedZero,
	input wire logic [31:0] modeDecel,
	input wire logic [31:0] quickDecel,
	output logic driverEnable,
	output hrs_pkg::hrs_brake_t brakeSel,
	output logic [31:0] rampDecel,
	output logic followMonEn,
	output hrs_pkg::hrs_pstate_t powerState,
	output logic irq
);
	import hrs_pkg::*;

	typedef struct packed {
		logic [15:0] ctrl;
		logic [7:0] mode;
		logic [15:0] qsOpt;
		logic [15:0] sdOpt;
		logic [15:0] doOpt;
		logic [15:0] hlOpt;
		logic [15:0] flOpt;
		logic [15:0] feOpt;
		logic [31:0] feWin;
		logic [31:0] slipMax;
		logic [15:0] errHist;
		logic [IRQ_W-1:0] irqStat;
		logic [IRQ_W-1:0] irqEn;
		hrs_pstate_t ps;
		hrs_pstate_t target;
		hrs_brake_t brake;
		logic ramping;
		logic halting;
		logic qsnPrev;
		logic frstPrev;
		logic [1:0] limSync;
		logic [1:0] fltSync;
		logic [1:0] folSync;
		logic [1:0] slpSync;
		logic [1:0] zeroSync;
		logic fltPrev;
		logic folPrev;
		logic [31:0] rdata;
		logic ack;
		logic [31:0] decel;
		logic drvEn;
		logic monEn;
		logic irqOut;
	} hrs_state_t;

	hrs_state_t st_r;
	hrs_state_t st_nxt;

	////////////////////////////////////////////////////////////////////////
	// Helper functions for option validity and decoding.

	// Maps a plain braking option (0, 1, 2) onto a brake action.
	function automatic hrs_brake_t brakeOf(input logic [15:0] opt);
		unique case (opt)
			OPT_COAST: brakeOf = BR_COAST;
			OPT_SLOW, OPT_SLOW_HOLD: brakeOf = BR_SLOW;
			OPT_QUICK, OPT_QUICK_HOLD: brakeOf = BR_QUICK;
			default: brakeOf = BR_NONE;
		endcase
	endfunction : brakeOf

	// Accepts only the codes that the addressed option object defines.
	function automatic logic optValid(input logic [5:0] a,
		input logic [15:0] v);
		unique case (a)
			OFS_QSOPT: optValid = (v <= OPT_QUICK) ||
				(v == OPT_SLOW_HOLD) || (v == OPT_QUICK_HOLD);
			OFS_SDOPT, OFS_DOOPT: optValid = (v <= OPT_SLOW);
			OFS_HLOPT: optValid = (v == OPT_SLOW) || (v == OPT_QUICK);
			OFS_FLOPT: optValid = (v <= OPT_QUICK);
			OFS_FEOPT: optValid = (v <= OPT_QUICK) || (v == OPT_NONE);
			default: optValid = 1'b1;
		endcase
	endfunction : optValid

	////////////////////////////////////////////////////////////////////////
	// Next-state logic for the bus slave, events and braking sequencer.
	always_comb begin
		logic wr;
		logic isOpt;
		logic qsnRise;
		logic frstRise;
		logic fltRise;
		logic folRise;
		logic limit;
		logic haltOk;
		logic cmdShut;
		logic cmdOn;
		logic cmdEnop;
		logic [IRQ_W-1:0] ev;
		hrs_brake_t hb;
		wr = 1'b0;
		isOpt = 1'b0;
		ev = '0;
		hb = BR_NONE;
		// Locals start at a known value on every pass, so none of them can
		// hold state as a latch.
		qsnRise = 1'b0;
		frstRise = 1'b0;
		fltRise = 1'b0;
		folRise = 1'b0;
		limit = 1'b0;
		haltOk = 1'b0;
		cmdShut = 1'b0;
		cmdOn = 1'b0;
		cmdEnop = 1'b0;
		st_nxt = st_r;
		st_nxt.ack = 1'b0;
		// Two-flop synchronisers for pin-level inputs.
		st_nxt.limSync = {st_r.limSync[0], limitSwitch};
		st_nxt.fltSync = {st_r.fltSync[0], faultEvent};
		st_nxt.folSync = {st_r.folSync[0], followErr};
		st_nxt.slpSync = {st_r.slpSync[0], slipErr};
		st_nxt.zeroSync = {st_r.zeroSync[0], speedZero};
		st_nxt.fltPrev = st_r.fltSync[1];
		st_nxt.folPrev = st_r.folSync[1] | st_r.slpSync[1];
		limit = st_r.limSync[1];
		fltRise = st_r.fltSync[1] & ~st_r.fltPrev;
		// Monitoring is off by either magic value.
		folRise = (st_r.folSync[1] | st_r.slpSync[1]) & ~st_r.folPrev &
			(st_r.feWin != FEWIN_OFF) & (st_r.slipMax != SLIP_OFF);

		// Bus access: one wait cycle, answered when ack is high.
		if ((avs_read | avs_write) & ~st_r.ack) begin
			st_nxt.ack = 1'b1;
			unique case (avs_address)
				OFS_CTRL: st_nxt.rdata = {16'h0000, st_r.ctrl};
				OFS_MODE: st_nxt.rdata = {24'h000000, st_r.mode};
				OFS_QSOPT: st_nxt.rdata = {{16{st_r.qsOpt[15]}}, st_r.qsOpt};
				OFS_SDOPT: st_nxt.rdata = {{16{st_r.sdOpt[15]}}, st_r.sdOpt};
				OFS_DOOPT: st_nxt.rdata = {{16{st_r.doOpt[15]}}, st_r.doOpt};
				OFS_HLOPT: st_nxt.rdata = {{16{st_r.hlOpt[15]}}, st_r.hlOpt};
				OFS_FLOPT: st_nxt.rdata = {{16{st_r.flOpt[15]}}, st_r.flOpt};
				OFS_FEOPT: st_nxt.rdata = {{16{st_r.feOpt[15]}}, st_r.feOpt};
				OFS_FEWIN: st_nxt.rdata = st_r.feWin;
				OFS_SLIPMAX: st_nxt.rdata = st_r.slipMax;
				OFS_STATUS: st_nxt.rdata = {20'h00000, st_r.ramping,
					st_r.brake, st_r.halting, st_r.target, st_r.ps};
				OFS_ERRHIST: st_nxt.rdata = {16'h0000, st_r.errHist};
				OFS_IRQSTAT: st_nxt.rdata = {27'h0000000, st_r.irqStat};
				OFS_IRQEN: st_nxt.rdata = {27'h0000000, st_r.irqEn};
				default: st_nxt.rdata = 32'h00000000;
			endcase
		end

		// A write lands only at the edge where waitrequest is low, so the
		// register and the master agree on when the transfer completed.
		wr = avs_write & st_r.ack;

		// Register writes; reserved option codes are dropped.
		if (wr) begin
			isOpt = (avs_address >= OFS_QSOPT) && (avs_address <= OFS_FEOPT);
			if (isOpt && !optValid(avs_address, avs_writedata[15:0])) begin
				ev[IRQ_REJECT] = 1'b1;
			end else begin
				unique case (avs_address)
					OFS_CTRL: st_nxt.ctrl = avs_writedata[15:0];
					OFS_MODE: st_nxt.mode = avs_writedata[7:0];
					OFS_QSOPT: st_nxt.qsOpt = avs_writedata[15:0];
					OFS_SDOPT: st_nxt.sdOpt = avs_writedata[15:0];
					OFS_DOOPT: st_nxt.doOpt = avs_writedata[15:0];
					OFS_HLOPT: st_nxt.hlOpt = avs_writedata[15:0];
					OFS_FLOPT: st_nxt.flOpt = avs_writedata[15:0];
					OFS_FEOPT: st_nxt.feOpt = avs_writedata[15:0];
					OFS_FEWIN: st_nxt.feWin = avs_writedata;
					OFS_SLIPMAX: st_nxt.slipMax = avs_writedata;
					OFS_IRQEN: st_nxt.irqEn = avs_writedata[IRQ_W-1:0];
					default: ;
				endcase
			end
		end

		// Edge detection on the control word bits.
		st_nxt.qsnPrev = st_r.ctrl[CW_QSN];
		st_nxt.frstPrev = st_r.ctrl[CW_FRST];
		qsnRise = st_r.ctrl[CW_QSN] & ~st_r.qsnPrev;
		frstRise = st_r.ctrl[CW_FRST] & ~st_r.frstPrev;
		cmdShut = ~st_r.ctrl[CW_FRST] & ~st_r.ctrl[CW_SWON] &
			st_r.ctrl[CW_VOLT] & st_r.ctrl[CW_QSN];
		cmdOn = ~st_r.ctrl[CW_FRST] & st_r.ctrl[CW_SWON] &
			st_r.ctrl[CW_VOLT] & st_r.ctrl[CW_QSN];
		cmdEnop = cmdOn & st_r.ctrl[CW_ENOP];
		haltOk = (st_r.mode == MODE_PP) || (st_r.mode == MODE_VL) ||
			(st_r.mode == MODE_PV) || (st_r.mode == MODE_TQ) ||
			(st_r.mode == MODE_IP);

		// Power state machine and braking sequencer.
		if (fltRise | folRise) begin
			// Errors pre-empt everything and log a code.
			st_nxt.errHist = fltRise ? ERR_FAULT :
				(st_r.slpSync[1] ? ERR_SLIP : ERR_FOLLOW);
			ev[IRQ_FAULT] = fltRise;
			ev[IRQ_FOLLOW] = folRise;
			hb = fltRise ? brakeOf(st_r.flOpt) :
				brakeOf(st_r.feOpt);
			if (hb != BR_NONE) begin
				st_nxt.ps = PS_FRA;
				st_nxt.target = PS_FAULT;
				st_nxt.brake = hb;
				st_nxt.ramping = (hb != BR_COAST);
				st_nxt.halting = 1'b0;
			end
		end else if (st_r.ramping) begin
			// Hold the origin state until standstill.
			if (st_r.zeroSync[1]) begin
				st_nxt.ramping = 1'b0;
				st_nxt.ps = st_r.target;
				st_nxt.brake = (st_r.target == PS_QSA || st_r.halting) ?
					st_r.brake : BR_COAST;
				if (st_r.target != PS_QSA && !st_r.halting) begin
					ev[IRQ_STOPPED] = 1'b1;
				end
			end
		end else begin
			unique case (st_r.ps)
				PS_SOD: if (cmdShut) st_nxt.ps = PS_RTSO;
				PS_RTSO: if (cmdOn) st_nxt.ps = PS_SWON;
				PS_SWON: if (cmdEnop) begin
					st_nxt.ps = PS_OPEN;
					st_nxt.brake = BR_NONE;
				end else if (cmdShut) st_nxt.ps = PS_RTSO;
				PS_OPEN: begin
					if (~st_r.ctrl[CW_QSN] | limit) begin
						// Commanded or limit quick stop.
						ev[IRQ_QSTOP] = 1'b1;
						hb = brakeOf(st_r.qsOpt);
						st_nxt.brake = hb;
						st_nxt.ps = (hb == BR_COAST) ? PS_SOD : PS_OPEN;
						st_nxt.ramping = (hb != BR_COAST);
						st_nxt.target = (st_r.qsOpt == OPT_SLOW_HOLD ||
							st_r.qsOpt == OPT_QUICK_HOLD) ?
							PS_QSA : PS_SOD;
					end else if (cmdShut) begin
						hb = brakeOf(st_r.sdOpt);
						st_nxt.brake = hb;
						st_nxt.ramping = (hb == BR_SLOW);
						st_nxt.target = PS_RTSO;
						if (hb == BR_COAST) st_nxt.ps = PS_RTSO;
					end else if (cmdOn & ~st_r.ctrl[CW_ENOP]) begin
						hb = brakeOf(st_r.doOpt);
						st_nxt.brake = hb;
						st_nxt.ramping = (hb == BR_SLOW);
						st_nxt.target = PS_SWON;
						if (hb == BR_COAST) st_nxt.ps = PS_SWON;
					end else if (st_r.ctrl[CW_HALT] & haltOk) begin
						// Halt ramps but stays enabled.
						st_nxt.brake = brakeOf(st_r.hlOpt);
						st_nxt.halting = 1'b1;
						st_nxt.ramping = ~st_r.halting;
						st_nxt.target = PS_OPEN;
					end else begin
						st_nxt.halting = 1'b0;
						st_nxt.brake = BR_NONE;
					end
					if (~st_r.ctrl[CW_VOLT]) begin
						st_nxt.ps = PS_SOD; // Disable voltage coasts.
						st_nxt.brake = BR_COAST;
						st_nxt.ramping = 1'b0;
						st_nxt.halting = 1'b0;
					end
				end
				PS_QSA: if (qsnRise & cmdEnop) begin
					st_nxt.ps = PS_OPEN;
					st_nxt.brake = BR_NONE;
				end else if (~st_r.ctrl[CW_VOLT]) begin
					st_nxt.ps = PS_SOD;
					st_nxt.brake = BR_COAST;
				end
				PS_FRA: st_nxt.ps = PS_FAULT;
				PS_FAULT: if (frstRise) begin
					st_nxt.ps = PS_SOD;
					st_nxt.brake = BR_COAST;
				end
				default: st_nxt.ps = PS_SOD;
			endcase
			if (st_r.ps != PS_OPEN) st_nxt.halting = 1'b0;
			if (~st_r.ctrl[CW_VOLT] && st_r.ps != PS_FAULT &&
				st_r.ps != PS_QSA && st_r.ps != PS_OPEN) begin
				st_nxt.ps = PS_SOD;
			end
		end

		// Ramp deceleration source for the chosen brake.
		st_nxt.decel = (st_nxt.brake == BR_QUICK) ? quickDecel :
			(st_nxt.brake == BR_SLOW) ? modeDecel : 32'h00000000;

		// Sticky interrupt bits: a new event wins over the clear.
		if (wr && avs_address == OFS_IRQCLR) begin
			st_nxt.irqStat = st_r.irqStat & ~avs_writedata[IRQ_W-1:0];
		end
		st_nxt.irqStat = st_nxt.irqStat | ev;

		// Decoded outputs are registered so that no output glitches.
		// The driver is off for a coast, and outside operation, quick stop and fault reaction unless ramping.
		st_nxt.drvEn = (st_nxt.brake != BR_COAST) &&
			(st_nxt.ps == PS_OPEN || st_nxt.ps == PS_QSA ||
			st_nxt.ps == PS_FRA || st_nxt.ramping);
		// Monitoring is off for either magic value.
		st_nxt.monEn = (st_nxt.feWin != FEWIN_OFF) &&
			(st_nxt.slipMax != SLIP_OFF);
		// Level interrupt from the enabled sticky bits.
		st_nxt.irqOut = |(st_nxt.irqStat & st_nxt.irqEn);
	end

	////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
			st_r.qsOpt <= RST_QSOPT;
			st_r.sdOpt <= RST_SDOPT;
			st_r.doOpt <= RST_DOOPT;
			st_r.hlOpt <= RST_HLOPT;
			st_r.flOpt <= RST_FLOPT;
			st_r.feOpt <= RST_FEOPT;
			st_r.feWin <= RST_FEWIN;
			st_r.slipMax <= RST_SLIPMAX;
			st_r.ps <= PS_SOD;
			st_r.brake <= BR_COAST;
			st_r.monEn <= 1'b1; // Reset window and limit keep monitoring on.
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register; only waitrequest is
	// combinational, as the handshake needs it in the request cycle.
	assign avs_readdata = st_r.rdata;
	assign avs_waitrequest = (avs_read | avs_write) & ~st_r.ack;
	assign driverEnable = st_r.drvEn;
	assign brakeSel = st_r.brake;
	assign rampDecel = st_r.decel;
	assign followMonEn = st_r.monEn;
	assign powerState = st_r.ps;
	assign irq = st_r.irqOut;

endmodule : hrs_halt_reaction_selector

// file: hrs_motor_model.sv
// Behavioural motor that winds down whenever it is not driven.
module hrs_motor_model (
	input logic ref_clk,
	input logic arst_n,
	input logic slowStop,
	input logic driverEnable,
	input hrs_pkg::hrs_brake_t brakeSel,
	output logic speedZero
);
	timeunit 1ns;
	timeprecision 1ps;
	import hrs_pkg::*;
	logic [5:0] speed_r;
	// A long spin-down stands for a heavy load; a short one for a light one.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			speed_r <= 6'h0;
		end else if (driverEnable && brakeSel == BR_NONE) begin
			speed_r <= slowStop ? 6'h3c : 6'h0c;
		end else if (speed_r != 6'h0) begin
			speed_r <= speed_r - 6'h1;
		end
	end
	assign speedZero = (speed_r == 6'h0);
endmodule : hrs_motor_model

// file: hrs_pkg.sv
// Package of constants and types for the halt reaction selector.
package hrs_pkg;

	// Register byte offsets on the Avalon-MM slave.
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_MODE = 6'h04;
	localparam logic [5:0] OFS_QSOPT = 6'h08;
	localparam logic [5:0] OFS_SDOPT = 6'h0c;
	localparam logic [5:0] OFS_DOOPT = 6'h10;
	localparam logic [5:0] OFS_HLOPT = 6'h14;
	localparam logic [5:0] OFS_FLOPT = 6'h18;
	localparam logic [5:0] OFS_FEOPT = 6'h1c;
	localparam logic [5:0] OFS_FEWIN = 6'h20;
	localparam logic [5:0] OFS_SLIPMAX = 6'h24;
	localparam logic [5:0] OFS_STATUS = 6'h28;
	localparam logic [5:0] OFS_ERRHIST = 6'h2c;
	localparam logic [5:0] OFS_IRQSTAT = 6'h30;
	localparam logic [5:0] OFS_IRQEN = 6'h34;
	localparam logic [5:0] OFS_IRQCLR = 6'h38;

	// Control word bit positions.
	localparam int CW_SWON = 0;
	localparam int CW_VOLT = 1;
	localparam int CW_QSN = 2;
	localparam int CW_ENOP = 3;
	localparam int CW_FRST = 7;
	localparam int CW_HALT = 8;

	// Operating mode codes that honour the halt bit.
	localparam logic [7:0] MODE_PP = 8'h01;
	localparam logic [7:0] MODE_VL = 8'h02;
	localparam logic [7:0] MODE_PV = 8'h03;
	localparam logic [7:0] MODE_TQ = 8'h04;
	localparam logic [7:0] MODE_IP = 8'h07;

	// Option code values.
	localparam logic [15:0] OPT_NONE = 16'hffff;
	localparam logic [15:0] OPT_COAST = 16'h0000;
	localparam logic [15:0] OPT_SLOW = 16'h0001;
	localparam logic [15:0] OPT_QUICK = 16'h0002;
	localparam logic [15:0] OPT_SLOW_HOLD = 16'h0005;
	localparam logic [15:0] OPT_QUICK_HOLD = 16'h0006;

	// Reset values of option registers.
	localparam logic [15:0] RST_QSOPT = 16'h0002;
	localparam logic [15:0] RST_SDOPT = 16'h0001;
	localparam logic [15:0] RST_DOOPT = 16'h0001;
	localparam logic [15:0] RST_HLOPT = 16'h0001;
	localparam logic [15:0] RST_FLOPT = 16'h0002;
	localparam logic [15:0] RST_FEOPT = 16'h0002;
	localparam logic [31:0] RST_FEWIN = 32'h00000100;
	localparam logic [31:0] RST_SLIPMAX = 32'h00000100;

	// Values that switch following-error monitoring off.
	localparam logic [31:0] FEWIN_OFF = 32'hffffffff;
	localparam logic [31:0] SLIP_OFF = 32'h7fffffff;

	// Error history codes.
	localparam logic [15:0] ERR_FAULT = 16'h1000;
	localparam logic [15:0] ERR_FOLLOW = 16'h8611;
	localparam logic [15:0] ERR_SLIP = 16'h8612;

	// Interrupt status bit positions.
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_FOLLOW = 1;
	localparam int IRQ_QSTOP = 2;
	localparam int IRQ_STOPPED = 3;
	localparam int IRQ_REJECT = 4;
	localparam int IRQ_W = 5;

	// Power state codes.
	typedef enum logic [3:0] {
		PS_SOD = 4'h0,
		PS_RTSO = 4'h1,
		PS_SWON = 4'h2,
		PS_OPEN = 4'h3,
		PS_QSA = 4'h4,
		PS_FRA = 4'h5,
		PS_FAULT = 4'h6
	} hrs_pstate_t;

	// Braking action selected for the motion generator.
	typedef enum logic [1:0] {
		BR_NONE = 2'h0,
		BR_COAST = 2'h1,
		BR_SLOW = 2'h2,
		BR_QUICK = 2'h3
	} hrs_brake_t;

endpackage : hrs_pkg

// file: hrs_props.sv
// Port-level checker for the halt reaction selector.
module hrs_props (
	input logic ref_clk,
	input logic arst_n,
	input logic avs_read,
	input logic avs_write,
	input logic avs_waitrequest,
	input logic limitSwitch,
	input logic speedZero,
	input logic [31:0] modeDecel,
	input logic [31:0] quickDecel,
	input logic driverEnable,
	input hrs_pkg::hrs_brake_t brakeSel,
	input logic [31:0] rampDecel,
	input hrs_pkg::hrs_pstate_t powerState
);
	timeunit 1ns;
	timeprecision 1ps;
	import hrs_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////
	// Four quiet samples cover the two-flop sync and the edge stage.
	sequence stillMoving;
		!speedZero [*4];
	endsequence
	sequence steadyRamp;
		brakeSel inside {BR_SLOW, BR_QUICK} && $stable(brakeSel);
	endsequence
	waitOne_a: assert property ((avs_read | avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("bus wait too long");
	idleWait_a: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
		else $error("wait without request");
	coastOff_a: assert property (brakeSel == BR_COAST |-> !driverEnable
		&& rampDecel == 32'h0) else $error("coast keeps driver on");
	noneDecel_a: assert property (brakeSel == BR_NONE |-> rampDecel == 32'h0)
		else $error("idle ramp not zero");
	slowDecel_a: assert property (brakeSel == BR_SLOW |->
		rampDecel == $past(modeDecel)) else $error("slow ramp decel wrong");
	quickDecel_a: assert property (brakeSel == BR_QUICK |->
		rampDecel == $past(quickDecel)) else $error("quick ramp decel wrong");
	rampHold_a: assert property (stillMoving ##0 steadyRamp |=>
		$stable(powerState)) else $error("state left during ramp");
	offState_a: assert property (powerState inside {PS_SOD, PS_FAULT} |->
		!driverEnable) else $error("driver on while disabled");
	// The limit starts quick stop braking within the sync delay; the state
	// moves at once for a coast, otherwise only once the ramp has brought the motor to rest.
	limitQs_a: assert property ($rose(limitSwitch) && powerState == PS_OPEN
		|-> ##[1:8] brakeSel != BR_NONE)
		else $error("limit switch ignored");
endmodule : hrs_props

// file: tb_top.sv
// Self-checking testbench for the halt reaction selector.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import hrs_pkg::*;
	logic ref_clk, arst_n, avs_read, avs_write, avs_waitrequest, irq;
	logic limitSwitch, faultEvent, followErr, slipErr, slowStop;
	logic speedZero, driverEnable, followMonEn;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, modeDecel, quickDecel, rampDecel;
	hrs_brake_t brakeSel;
	hrs_pstate_t powerState;
	int failures = 0;
	int checks = 0;
	localparam logic [5:0] RA[5] = '{OFS_QSOPT, OFS_SDOPT, OFS_HLOPT,
		OFS_FLOPT, OFS_FEOPT};
	localparam logic [31:0] BAD[5] = '{32'h3, 32'h2, 32'h0, 32'h3, 32'hfffffffe};
	localparam logic [15:0] RV[5] = '{RST_QSOPT, RST_SDOPT, RST_HLOPT,
		RST_FLOPT, RST_FEOPT};
	localparam logic [31:0] QSO[5] = '{32'h0, 32'h1, 32'h2, 32'h5, 32'h6};
	localparam logic [7:0] HM[6] = '{MODE_PP, MODE_VL, MODE_PV, MODE_TQ,
		MODE_IP, 8'h06};
	hrs_halt_reaction_selector dut (.ref_clk, .arst_n, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .limitSwitch,
		.faultEvent, .followErr, .slipErr, .speedZero, .modeDecel, .quickDecel,
		.driverEnable, .brakeSel, .rampDecel, .followMonEn, .powerState, .irq);
	hrs_motor_model motor (.ref_clk, .arst_n, .slowStop, .driverEnable,
		.brakeSel, .speedZero);
	////////////////////////////////////////
	// Clock at 25 MHz.
	always #20 ref_clk = ~ref_clk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task tally_and_finish;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish
	// One bus cycle; the request is held until waitrequest is seen low.
	task automatic bus(input logic w, input logic [5:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'h0 && n < 50);
		q = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		if (n >= 50) chk(32'h1, 32'h0);
	endtask : bus
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'h1, a, d, q);
	endtask : wr
	task automatic rd(input logic [5:0] a, output logic [31:0] q);
		bus(1'h0, a, 32'h0, q);
	endtask : rd
	task automatic waitState(input hrs_pstate_t ps);
		int n;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (powerState !== ps && n < 200);
		chk(powerState, ps);
	endtask : waitState
	task automatic waitBrake(input hrs_brake_t b);
		int n;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (brakeSel !== b && n < 40);
		chk(brakeSel, b);
		chk(rampDecel, b == BR_SLOW ? modeDecel :
			b == BR_QUICK ? quickDecel : 32'h0);
	endtask : waitBrake
	function automatic hrs_brake_t brk(input logic [31:0] o);
		case (o)
			32'h0: return BR_COAST;
			32'h1, 32'h5: return BR_SLOW;
			32'h2, 32'h6: return BR_QUICK;
			default: return BR_NONE;
		endcase
	endfunction : brk
	task automatic goOpen;
		wr(OFS_CTRL, 32'h6);
		waitState(PS_RTSO);
		wr(OFS_CTRL, 32'h7);
		waitState(PS_SWON);
		wr(OFS_CTRL, 32'hf);
		waitState(PS_OPEN);
	endtask : goOpen
	////////////////////////////////////////
	// Reset values, refused option writes and the interrupt path.
	task automatic regsReject;
		logic [31:0] d;
		chk(brakeSel, BR_COAST);
		chk(followMonEn, 1'h1);
		for (int i = 0; i < 5; i++) begin
			wr(RA[i], BAD[i]);
			rd(RA[i], d);
			chk(d, {16'h0, RV[i]});
		end
		@(negedge ref_clk);
		chk(irq, 1'h0);
		rd(OFS_IRQSTAT, d);
		chk(d[4], 1'h1);
		wr(OFS_IRQEN, 32'h10);
		@(negedge ref_clk);
		chk(irq, 1'h1);
		wr(OFS_IRQCLR, 32'h10);
		@(negedge ref_clk);
		chk(irq, 1'h0);
		rd(6'h3c, d);
		chk(d, 32'h0);
	endtask : regsReject
	task automatic quickStops;
		logic [31:0] o;
		for (int i = 0; i < 5; i++) begin
			o = QSO[i];
			wr(OFS_QSOPT, o);
			slowStop <= o[0];
			goOpen();
			wr(OFS_CTRL, 32'hb);
			waitBrake(brk(o));
			waitState(o > 32'h2 ? PS_QSA : PS_SOD);
			if (o > 32'h2) begin
				chk(driverEnable, 1'h1);
				wr(OFS_CTRL, 32'hf);
				waitState(PS_OPEN);
			end
		end
		wr(OFS_QSOPT, 32'h2);
		goOpen();
		@(posedge ref_clk);
		limitSwitch <= 1'h1;
		waitBrake(BR_QUICK);
		waitState(PS_SOD);
		@(posedge ref_clk);
		limitSwitch <= 1'h0;
	endtask : quickStops
	task automatic stops;
		logic [31:0] v;
		for (int o = 0; o < 2; o++) begin
			v = o[0] ? 32'h1 : 32'h0;
			wr(OFS_SDOPT, v);
			wr(OFS_DOOPT, v);
			slowStop <= o[0];
			goOpen();
			wr(OFS_CTRL, 32'h6);
			waitBrake(brk(v));
			if (v[0]) chk(powerState, PS_OPEN);
			waitState(PS_RTSO);
			goOpen();
			wr(OFS_CTRL, 32'h7);
			waitBrake(brk(v));
			waitState(PS_SWON);
		end
	endtask : stops
	task automatic halts;
		@(posedge ref_clk);
		slowStop <= 1'h0; // A short spin keeps each halt ramp brief.
		goOpen();
		for (int i = 0; i < 6; i++) begin
			wr(OFS_HLOPT, i[0] ? 32'h2 : 32'h1);
			wr(OFS_MODE, {24'h0, HM[i]});
			wr(OFS_CTRL, 32'h10f);
			if (i == 5) begin
				repeat (8) @(negedge ref_clk);
				chk(brakeSel, BR_NONE);
			end else begin
				waitBrake(i[0] ? BR_QUICK : BR_SLOW);
			end
			chk(powerState, PS_OPEN);
			wr(OFS_CTRL, 32'hf);
			waitBrake(BR_NONE);
		end
	endtask : halts
	task automatic faults;
		logic [31:0] d;
		for (int o = 0; o < 3; o++) begin
			wr(OFS_FLOPT, o[1] ? 32'h2 : {31'h0, o[0]});
			goOpen();
			@(posedge ref_clk);
			faultEvent <= 1'h1;
			waitBrake(brk(o[1] ? 32'h2 : {31'h0, o[0]}));
			waitState(PS_FAULT);
			@(posedge ref_clk);
			faultEvent <= 1'h0;
			rd(OFS_ERRHIST, d);
			chk(d[15:0], ERR_FAULT);
			wr(OFS_CTRL, 32'h80);
			waitState(PS_SOD);
		end
	endtask : faults
	task automatic follows;
		logic [31:0] d;
		wr(OFS_FEOPT, 32'hffffffff);
		goOpen();
		@(posedge ref_clk);
		followErr <= 1'h1;
		repeat (8) @(posedge ref_clk);
		followErr <= 1'h0;
		@(negedge ref_clk);
		chk(powerState, PS_OPEN);
		rd(OFS_ERRHIST, d);
		chk(d[15:0], ERR_FOLLOW);
		wr(OFS_FEOPT, 32'h2);
		slipErr <= 1'h1;
		waitBrake(BR_QUICK);
		waitState(PS_FAULT);
		@(posedge ref_clk);
		slipErr <= 1'h0;
		rd(OFS_ERRHIST, d);
		chk(d[15:0], ERR_SLIP);
		wr(OFS_FEWIN, FEWIN_OFF);
		@(negedge ref_clk);
		chk(followMonEn, 1'h0);
		wr(OFS_FEWIN, RST_FEWIN);
		wr(OFS_SLIPMAX, SLIP_OFF);
		@(negedge ref_clk);
		chk(followMonEn, 1'h0);
		wr(OFS_SLIPMAX, RST_SLIPMAX);
		@(negedge ref_clk);
		chk(followMonEn, 1'h1);
	endtask : follows
	// Main sequence: reset for 12 cycles, then each scenario in turn.
	initial begin
		ref_clk = 1'h0;
		arst_n = 1'h0;
		{avs_read, avs_write, limitSwitch, faultEvent} = 4'h0;
		{followErr, slipErr, slowStop} = 3'h0;
		avs_address = 6'h0;
		avs_writedata = 32'h0;
		modeDecel = 32'h123;
		quickDecel = 32'h456;
		repeat (12) @(posedge ref_clk);
		arst_n <= 1'h1;
		regsReject();
		quickStops();
		stops();
		halts();
		faults();
		follows();
		tally_and_finish();
	end
	// Watchdog well beyond the expected run length.
	initial begin
		repeat (40000) @(posedge ref_clk);
		failures++;
		tally_and_finish();
	end
endmodule : tb_top
bind hrs_halt_reaction_selector hrs_props props (.ref_clk, .arst_n, .avs_read,
	.avs_write, .avs_waitrequest, .limitSwitch, .speedZero, .modeDecel,
	.quickDecel, .driverEnable, .brakeSel, .rampDecel, .powerState);
